// ===== rtl/swd_access_lock.sv
// Serial debug acquisition, packet engine, pin muxing and security lock
`timescale 1ns/1ps
`include "swd_lock_regs.svh"
// Notes on behaviour
// (RULE_01) Host debug clock at most CPU clock/3
// (RULE_02) Two pins: host clock, shared data
// (RULE_03) Serial debug on one pin pair only
// (RULE_04) Acquire sequence must land in key window
// (RULE_05) Reacquire always allowed; can re-enable JTAG
// (RULE_06) JTAG enables serial debug; disabled means GPIO
// (RULE_07) Same debug access, no scan chains
// (RULE_08) Serial debug: any trace; JTAG: parallel only
// (RULE_09) Parallel trace five pins; wire trace shares
// (RULE_10) Protection cleared only by full erase; the code also clears it on every system reset
// (RULE_11) Block operations only when block permits
// (RULE_12) Latch matches when 28 of 32 agree
// (RULE_13) Lock blocks debug and latch changes
// (RULE_14) Latch output sampled only at reset
// (RULE_15) Key write only without flash protection
// (RULE_16) Access stays until next reset
// (RULE_17) Lock disables every external port
// (RULE_18) Latch readable over serial debug
// (RULE_19) Six address, two literal breakpoints, halt, step
// (RULE_20) Debug and trace start off, firmware enables
// (RULE_21) Packets: request, turnaround, ack, data, parity
module swd_access_lock (
  input wire logic clk_sys, // System clock, 50 MHz
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic por, // Power-on clear of latch cells
  input wire swd_lock_pkg::pair_in_type jtag_in, // Mode and clock pins
  input wire swd_lock_pkg::pair_in_type usb_in, // USB pin pair
  output logic tms_out, // Mode pin output
  output logic tms_oe, // Mode pin output enable
  output logic dm_out, // USB data pin output
  output logic dm_oe, // USB data pin output enable
  input wire logic gpio_tms_out, // GPIO drive for mode pin
  input wire logic gpio_tms_oe, // GPIO enable for mode pin
  input wire logic gpio_dm_out, // GPIO drive for USB pin
  input wire logic gpio_dm_oe, // GPIO enable for USB pin
  input wire logic jtag_tdo, // JTAG test data out
  input wire logic jtag_tdo_oe, // JTAG test data enable
  input wire logic swo_data, // Wire trace bit stream
  output logic tdo_out, // Shared test data pin output
  output logic tdo_oe, // Shared test data pin enable
  output logic ptrace_en, // Parallel trace port enable
  input wire logic jtag_swd_en, // Pulse from JTAG to enable
  output logic jtag_en, // JTAG port enabled
  output logic swd_on, // Serial debug acquired
  output logic swd_usb, // Acquired on the USB pair
  output logic locked, // Security lock in force
  output logic cpu_halt, // Halt request to the CPU
  output logic cpu_step, // Single-step pulse
  output logic erase_all, // Full erase pulse
  input wire logic blk_req, // Block operation request
  input wire logic [2:0] blk_idx, // Block number
  output logic blk_grant, // Block operation allowed
  input wire logic [3:0] addr, // Firmware byte address
  input wire logic [31:0] wdata, // Firmware write data
  input wire logic we, // Firmware write strobe
  input wire logic re, // Firmware read strobe
  output logic [31:0] rdata // Firmware read data
);
  //////////////////////////////////////////////////////////////////
  // Declarations
  swd_lock_pkg::pair_in_type j_s1_q, j_s2_q, j_s3_q; // Mode pair sync
  swd_lock_pkg::pair_in_type u_s1_q, u_s2_q, u_s3_q; // USB pair sync
  swd_lock_pkg::swd_state_type st_q; // Engine state
  swd_lock_pkg::swd_req_type req_w; // Header being received
  logic [7:0] req_q; // Header shift register
  logic [32:0] sh_q; // Data shift register
  logic [5:0] cnt_q; // Bit counter
  logic dout_q; // Data pin drive value
  logic [15:0] acq_j_q, acq_u_q; // Acquire sequence shifters
  logic [8:0] win_q; // Key window timer
  logic swd_q, usb_q; // Acquired, and on which pair
  logic jtag_q; // JTAG enable
  logic lock_q; // Lock sampled at reset
  logic halt_q, step_q, erase_q, prog_q; // Debug controls
  logic dbg_q; // Firmware debug enable
  logic [1:0] trace_q; // Firmware trace select
  logic [1:0] prot_q; // Flash protection level
  logic [7:0] perm_q; // Block permissions
  logic [31:0] nv_w; // Latch cell contents
  wire rise_j, rise_u, rise_w, din_w; // Selected pair events
  wire win_open, acq_j, acq_u; // Acquire conditions
  wire hdr_ok, wr_ok, key_ok; // Packet checks
  wire dp_wr, ctrl_wr, key_wr; // Debug port writes
  wire [31:0] rd_word, ctrl_word; // Debug port read words
  wire [31:0] fw_word, wd_w; // Firmware read mux, write word
  wire swo_on; // Wire trace active

  //////////////////////////////////////////////////////////////////
  // Two-flop synchronisers plus one delay stage for edges
  always_ff @(posedge clk_sys)
  begin
    j_s1_q <= jtag_in;
    j_s2_q <= j_s1_q;
    j_s3_q <= j_s2_q;
    u_s1_q <= usb_in;
    u_s2_q <= u_s1_q;
    u_s3_q <= u_s2_q;
  end

  // Host clock edges; needs at least three system clocks a bit
  assign rise_j = j_s2_q.clk & ~j_s3_q.clk; // [RULE_01] [RULE_02]
  assign rise_u = u_s2_q.clk & ~u_s3_q.clk; // [RULE_02]
  // Only the acquired pair feeds the engine
  assign rise_w = swd_q & ~lock_q & (usb_q ? rise_u : rise_j); // [RULE_03]
  assign din_w = usb_q ? u_s2_q.dat : j_s2_q.dat;

  //////////////////////////////////////////////////////////////////
  // Key window and acquisition
  assign win_open = win_q < `KEY_WIN_CYC; // [RULE_04]
  assign acq_j = rise_j && {j_s2_q.dat, acq_j_q[15:1]} == `ACQ_SEQ;
  assign acq_u = rise_u && {u_s2_q.dat, acq_u_q[15:1]} == `ACQ_SEQ;

  // Window timer runs once after each reset
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      win_q <= 9'h0;
    else if (win_open)
      win_q <= win_q + 9'h1;
  end

  // Sequence shifters, first bit ends up in bit 0
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      acq_j_q <= 16'h0;
      acq_u_q <= 16'h0;
    end
    else
    begin
      if (rise_j)
        acq_j_q <= {j_s2_q.dat, acq_j_q[15:1]};
      if (rise_u)
        acq_u_q <= {u_s2_q.dat, acq_u_q[15:1]};
    end
  end

  // Acquire state; a prior disable never blocks the window
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      swd_q <= 1'b0;
      usb_q <= 1'b0;
    end
    else if (lock_q)
      swd_q <= 1'b0; // [RULE_17]
    else if (!swd_q && win_open && (acq_j || acq_u)) // [RULE_04] [RULE_05]
    begin
      swd_q <= 1'b1;
      usb_q <= !acq_j; // Mode pair wins a tie [RULE_03]
    end
    else if (!swd_q && jtag_q && jtag_swd_en) // [RULE_06]
    begin
      swd_q <= 1'b1;
      usb_q <= 1'b0;
    end
    else if (ctrl_wr && wd_w[`DC_SWD_OFF_BIT])
      swd_q <= 1'b0; // Pins return to GPIO, except the mode pin while JTAG is enabled [RULE_06]
  end

  //////////////////////////////////////////////////////////////////
  // Packet engine
  assign req_w = swd_lock_pkg::swd_req_type'({din_w, req_q[7:1]});
  assign hdr_ok = req_w.start & ~req_w.stop & req_w.park &
                  (req_w.par == ^{req_w.apndp, req_w.rnw, req_w.addr}); // [RULE_21]
  assign wr_ok = (^{din_w, sh_q[32:1]}) == 1'b0; // Even parity over data+bit
  assign wd_w = sh_q[32:1]; // Word at the parity rise
  assign dp_wr = rise_w && st_q == swd_lock_pkg::ST_WDAT && cnt_q == 6'd32 && wr_ok;

  // One step per host clock rise
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || !swd_q)
    begin
      st_q <= swd_lock_pkg::ST_IDLE;
      cnt_q <= 6'h0;
      req_q <= 8'h0;
      sh_q <= 33'h0;
      dout_q <= 1'b0;
    end
    else if (rise_w)
    begin
      cnt_q <= cnt_q + 6'h1;
      case (st_q)
        swd_lock_pkg::ST_IDLE: // Wait for the start bit
        begin
          req_q <= {din_w, req_q[7:1]};
          cnt_q <= 6'h1;
          if (din_w)
            st_q <= swd_lock_pkg::ST_REQ;
        end
        swd_lock_pkg::ST_REQ: // Header bits
        begin
          req_q <= {din_w, req_q[7:1]};
          if (cnt_q == 6'd7)
            st_q <= hdr_ok ? swd_lock_pkg::ST_TRN1 : swd_lock_pkg::ST_IDLE;
        end
        swd_lock_pkg::ST_TRN1: // Turnaround, then drive OK
        begin
          st_q <= swd_lock_pkg::ST_ACK;
          cnt_q <= 6'h0;
          dout_q <= 1'b1;
        end
        swd_lock_pkg::ST_ACK: // Acknowledge 1,0,0 [RULE_21]
        begin
          dout_q <= 1'b0;
          if (cnt_q == 6'd2)
          begin
            cnt_q <= 6'h0;
            if (req_q[2])
            begin
              st_q <= swd_lock_pkg::ST_RDAT;
              sh_q <= {^rd_word, rd_word};
              dout_q <= rd_word[0];
            end
            else
              st_q <= swd_lock_pkg::ST_TRNW;
          end
        end
        swd_lock_pkg::ST_RDAT: // Read data then parity
        begin
          sh_q <= {1'b0, sh_q[32:1]};
          dout_q <= sh_q[1];
          if (cnt_q == 6'd32)
            st_q <= swd_lock_pkg::ST_TRN2;
        end
        swd_lock_pkg::ST_TRNW: // Turnaround before write data
        begin
          st_q <= swd_lock_pkg::ST_WDAT;
          cnt_q <= 6'h0;
        end
        swd_lock_pkg::ST_WDAT: // Write data then parity
        begin
          sh_q <= {din_w, sh_q[32:1]};
          if (cnt_q == 6'd32)
            st_q <= swd_lock_pkg::ST_IDLE;
        end
        swd_lock_pkg::ST_TRN2: // Release the data pin
          st_q <= swd_lock_pkg::ST_IDLE;
        default:
          st_q <= swd_lock_pkg::ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////
  // Debug port registers; no scan chain is reachable here
  assign ctrl_wr = dp_wr && req_q[4:3] == `DP_CTRL_IDX; // [RULE_07]
  assign key_ok = prot_q == 2'h0 && !lock_q; // [RULE_15]
  assign key_wr = dp_wr && req_q[4:3] == `DP_KEY_IDX && key_ok;
  assign ctrl_word = {26'h0, 2'h0, halt_q, 1'b0, ~swd_q, jtag_q};
  assign rd_word = req_q[4:3] == `DP_ID_IDX ? {`DEV_ID, 8'h0, `NUM_ADDR_BP, `NUM_LIT_BP} : // [RULE_19]
                   req_q[4:3] == `DP_CTRL_IDX ? ctrl_word :
                   req_q[4:3] == `DP_LATCH_IDX ? nv_w : // [RULE_18]
                   {28'h0, prot_q, key_ok, lock_q};

  // Control bits and command pulses written over the link
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      jtag_q <= `JTAG_EN_RST;
      halt_q <= 1'b0;
      step_q <= 1'b0;
      erase_q <= 1'b0;
      prog_q <= 1'b0;
    end
    else
    begin
      step_q <= ctrl_wr && wd_w[`DC_STEP_BIT] && dbg_q; // [RULE_19]
      erase_q <= ctrl_wr && wd_w[`DC_ERASE_BIT];
      prog_q <= ctrl_wr && wd_w[`DC_PROG_BIT] && key_ok;
      if (ctrl_wr)
      begin
        jtag_q <= wd_w[`DC_JTAG_EN_BIT]; // [RULE_05]
        halt_q <= wd_w[`DC_HALT_BIT] && dbg_q; // [RULE_19] [RULE_20]
      end
    end
  end

  //////////////////////////////////////////////////////////////////
  // Security latch and its reset-time sample
  swd_latch_cell u_latch (
    .clk_sys(clk_sys),
    .por(por),
    .vol_we(key_wr), // [RULE_15]
    .vol_wdata(wd_w),
    .prog(prog_q),
    .nv_rdata(nv_w)
  );

  // Lock follows the cells only while reset is held
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      lock_q <= swd_lock_pkg::key_match(nv_w); // [RULE_12] [RULE_14] [RULE_16]
  end

  //////////////////////////////////////////////////////////////////
  // Firmware registers
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      dbg_q <= 1'b0; // [RULE_20]
      trace_q <= `TRACE_NONE;
      perm_q <= `PERM_RST;
    end
    else if (we && addr == `FW_CTRL_OFS)
    begin
      dbg_q <= wdata[`FW_DBG_EN_BIT];
      trace_q <= wdata[`FW_TRACE_LSB +: 2];
    end
    else if (we && addr == `FW_PERM_OFS)
      perm_q <= wdata[7:0];
  end

  // Protection only rises, except on a full erase or a system reset
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      prot_q <= `PROT_RST;
    else if (erase_q && !lock_q)
      prot_q <= `PROT_RST; // [RULE_10]
    else if (we && addr == `FW_PROT_OFS && wdata[1:0] > prot_q)
      prot_q <= wdata[1:0]; // [RULE_10]
  end

  // Read data one cycle after the strobe
  assign fw_word = addr == `FW_CTRL_OFS ? {29'h0, trace_q, dbg_q} :
                   addr == `FW_PROT_OFS ? {30'h0, prot_q} :
                   addr == `FW_PERM_OFS ? {24'h0, perm_q} :
                   addr == `FW_STAT_OFS ? {27'h0, usb_q, swd_q, jtag_q, key_ok, lock_q} :
                   32'h0;
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      rdata <= 32'h0;
    else
      rdata <= re ? fw_word : 32'h0;
  end

  //////////////////////////////////////////////////////////////////
  // Pins and outputs
  // Wire trace sits on a JTAG pin, so JTAG must be off
  assign swo_on = trace_q == `TRACE_SWO && dbg_q && swd_q && !jtag_q && !lock_q; // [RULE_08] [RULE_09]
  assign ptrace_en = trace_q == `TRACE_PAR && dbg_q && (swd_q || jtag_q) && !lock_q; // [RULE_08] [RULE_09]
  assign tdo_out = swo_on ? swo_data : jtag_tdo;
  assign tdo_oe = swo_on | (jtag_en & jtag_tdo_oe);
  assign jtag_en = jtag_q & ~lock_q; // [RULE_17]
  // Engine drives the data pin during ack and read data
  assign tms_out = swd_q && !usb_q ? dout_q : gpio_tms_out; // [RULE_06]
  assign tms_oe = swd_q && !usb_q ? (st_q == swd_lock_pkg::ST_ACK || st_q == swd_lock_pkg::ST_RDAT) :
                  !jtag_en & gpio_tms_oe;
  assign dm_out = swd_q && usb_q ? dout_q : gpio_dm_out;
  assign dm_oe = swd_q && usb_q ? (st_q == swd_lock_pkg::ST_ACK || st_q == swd_lock_pkg::ST_RDAT) :
                 gpio_dm_oe;
  assign swd_on = swd_q;
  assign swd_usb = usb_q;
  assign locked = lock_q; // [RULE_13]
  assign cpu_halt = halt_q;
  assign cpu_step = step_q;
  assign erase_all = erase_q & ~lock_q; // [RULE_13]
  assign blk_grant = blk_req & perm_q[blk_idx] & ~lock_q; // [RULE_11]
endmodule

// ===== common/swd_lock_regs.svh
// Offsets, field positions, reset values and timing counts of the debug access block
`ifndef SWD_LOCK_REGS_SVH
`define SWD_LOCK_REGS_SVH
// Firmware register byte offsets
`define FW_CTRL_OFS 4'h0
`define FW_PROT_OFS 4'h4
`define FW_PERM_OFS 4'h8
`define FW_STAT_OFS 4'hc
// Firmware control fields
`define FW_DBG_EN_BIT 0
`define FW_TRACE_LSB 1
// Trace selections
`define TRACE_NONE 2'h0
`define TRACE_SWO 2'h1
`define TRACE_PAR 2'h2
// Debug port register indexes (request address bits)
`define DP_ID_IDX 2'h0
`define DP_CTRL_IDX 2'h1
`define DP_LATCH_IDX 2'h2
`define DP_KEY_IDX 2'h3
// Debug port control fields
`define DC_JTAG_EN_BIT 0
`define DC_SWD_OFF_BIT 1
`define DC_HALT_BIT 2
`define DC_STEP_BIT 3
`define DC_ERASE_BIT 4
`define DC_PROG_BIT 5
// Reset values
`define JTAG_EN_RST 1'b1
`define PROT_RST 2'h0
`define PERM_RST 8'h00
// Acquire sequence, arbitrary pattern
`define ACQ_SEQ 16'hb3d9
// Lock key, arbitrary value
`define LOCK_KEY 32'ha5c3_1e69
`define MATCH_MIN 6'd28
// Identity word, arbitrary value
`define DEV_ID 16'h1d2e
`define NUM_ADDR_BP 4'h6
`define NUM_LIT_BP 4'h2
// Key window after reset
`define KEY_WIN_NS 8000
`define CLK_PERIOD_NS 20
`define KEY_WIN_CYC 9'((`KEY_WIN_NS) / (`CLK_PERIOD_NS))
`endif

// ===== common/swd_lock_pkg.sv
// Types and the key-match function of the debug access block
package swd_lock_pkg;
  `include "swd_lock_regs.svh"
  // Packet engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_REQ = 3'b001,
    ST_TRN1 = 3'b010,
    ST_ACK = 3'b011,
    ST_RDAT = 3'b100,
    ST_TRNW = 3'b101,
    ST_WDAT = 3'b110,
    ST_TRN2 = 3'b111
  } swd_state_type;
  // Clock and data of one pin pair
  typedef struct packed {
    logic clk;
    logic dat;
  } pair_in_type;
  // Request header, first bit in bit 0
  typedef struct packed {
    logic park;
    logic stop;
    logic par;
    logic [1:0] addr;
    logic rnw;
    logic apndp;
    logic start;
  } swd_req_type;
  // True when at least the minimum count of bits equal the key
  function automatic logic key_match(input logic [31:0] v);
    logic [5:0] n;
    logic [31:0] same;
    n = 6'h0;
    same = v ~^ `LOCK_KEY;
    for (int i = 0; i < 32; i++)
    begin
      n = n + {5'h0, same[i]};
    end
    return n >= `MATCH_MIN;
  endfunction
endpackage

// ===== rtl/swd_latch_cell.sv
// Security latch, sealed once its cells hold the key: volatile copy and nonvolatile cells
`timescale 1ns/1ps
module swd_latch_cell (
  input wire logic clk_sys, // System clock
  input wire logic por, // Power-on clear of the cells
  input wire logic vol_we, // Load the volatile copy
  input wire logic [31:0] vol_wdata, // Key word to load
  input wire logic prog, // Copy volatile word into cells
  output logic [31:0] nv_rdata // Cell contents, registered
);
  logic [31:0] nv_q; // Nonvolatile cells
  logic [31:0] vol_q; // Volatile copy
  wire sealed_w; // Cells hold the key

  // A matching word seals the latch against writes and programming until power-on
  assign sealed_w = swd_lock_pkg::key_match(nv_q);
  assign nv_rdata = nv_q;

  //////////////////////////////////////////////////////////////////
  // Storage; only power-on clears it, system reset does not
  always_ff @(posedge clk_sys)
  begin
    if (por)
    begin
      nv_q <= 32'h0;
      vol_q <= 32'h0;
    end
    else
    begin
      if (vol_we && !sealed_w) // [RULE_13]
        vol_q <= vol_wdata;
      if (prog && !sealed_w) // [RULE_13]
        nv_q <= vol_q;
    end
  end
endmodule

// ===== dv/swd_access_lock_assertions.sv
// Concurrent checks on the ports of the debug access block
`timescale 1ns/1ps
module swd_access_lock_assertions (
  input wire logic clk_sys, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic blk_req, // Block request
  input wire logic blk_grant, // Block grant
  input wire logic locked, // Lock in force
  input wire logic swd_on, // Acquired
  input wire logic swd_usb, // On the USB pair
  input wire logic jtag_en, // JTAG enabled
  input wire logic erase_all, // Full erase pulse
  input wire logic cpu_halt, // Halt request
  input wire logic cpu_step, // Step pulse
  input wire logic ptrace_en, // Parallel trace enable
  input wire logic tms_out, // Mode pin drive
  input wire logic tms_oe, // Mode pin enable
  input wire logic gpio_tms_out, // GPIO mode pin drive
  input wire logic gpio_tms_oe, // GPIO mode pin enable
  input wire logic dm_out, // USB pin drive
  input wire logic dm_oe, // USB pin enable
  input wire logic gpio_dm_out, // GPIO USB pin drive
  input wire logic gpio_dm_oe // GPIO USB pin enable
);
  localparam int WIN_LIMIT = 410; // Key window plus pin sync delay
  logic [9:0] win_q; // Cycles since reset release, saturating
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////
  // Cycle counter for the key window
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      win_q <= 10'h0;
    else if (win_q != 10'h3ff)
      win_q <= win_q + 10'h1;
  end
  ////////////////////////////////
  // Properties
  property p_grant; blk_grant |-> blk_req && !locked; endproperty
  a_grant: assert property (p_grant) else $error("grant without request or while locked");
  property p_lock_stable; !$past(sys_rst) |-> $stable(locked); endproperty
  a_lock_stable: assert property (p_lock_stable) else $error("lock changed outside reset");
  property p_lock_ports; locked |-> !swd_on && !jtag_en; endproperty
  a_lock_ports: assert property (p_lock_ports) else $error("debug port open while locked");
  property p_lock_gate; locked |-> !erase_all && !cpu_halt && !cpu_step; endproperty
  a_lock_gate: assert property (p_lock_gate) else $error("debug action while locked");
  property p_step; cpu_step |=> !cpu_step; endproperty
  a_step: assert property (p_step) else $error("step longer than one cycle");
  property p_erase; erase_all |=> !erase_all; endproperty
  a_erase: assert property (p_erase) else $error("erase longer than one cycle");
  property p_pair; swd_on && $past(swd_on) |-> $stable(swd_usb); endproperty
  a_pair: assert property (p_pair) else $error("pin pair changed while acquired");
  property p_window; $rose(swd_on) && swd_usb |-> win_q <= WIN_LIMIT; endproperty
  a_window: assert property (p_window) else $error("acquired after key window");
  property p_gpio_tms; !swd_on && !jtag_en |-> tms_out == gpio_tms_out && tms_oe == gpio_tms_oe; endproperty
  a_gpio_tms: assert property (p_gpio_tms) else $error("mode pin not given to GPIO");
  property p_gpio_dm; !(swd_on && swd_usb) |-> dm_out == gpio_dm_out && dm_oe == gpio_dm_oe; endproperty
  a_gpio_dm: assert property (p_gpio_dm) else $error("USB pin not given to GPIO");
  property p_rst_off; $fell(sys_rst) |-> !ptrace_en && !cpu_halt; endproperty
  a_rst_off: assert property (p_rst_off) else $error("debug or trace on after reset");
  // Main scenarios
  c_acquire: cover property ($rose(swd_on) && swd_usb);
  c_grant: cover property (blk_grant);
  c_step: cover property (cpu_step);
  c_erase: cover property (erase_all);
endmodule
bind swd_access_lock swd_access_lock_assertions swd_access_lock_assertions_i (.clk_sys, .sys_rst, .blk_req,
  .blk_grant, .locked, .swd_on, .swd_usb, .jtag_en, .erase_all, .cpu_halt, .cpu_step, .ptrace_en, .tms_out,
  .tms_oe, .gpio_tms_out, .gpio_tms_oe, .dm_out, .dm_oe, .gpio_dm_out, .gpio_dm_oe);

// ===== dv/swd_host_model.sv
// Behavioural serial debug host on one pin pair
`timescale 1ns/1ps
`include "swd_lock_regs.svh"
module swd_host_model (
  input wire logic dev_out, // Device data drive
  input wire logic dev_oe, // Device data enable
  output swd_lock_pkg::pair_in_type pin // Clock and data at the pins
);
  logic hd = 1'b0; // Host data drive
  logic hoe = 1'b0; // Host drives data
  logic hclk = 1'b0; // Host clock, still between frames
  ////////////////////////////////
  // Wire level: device, else host, else inverse of last bit
  assign pin.clk = hclk;
  assign pin.dat = dev_oe ? dev_out : (hoe ? hd : ~hd);
  // One bit per 160 ns, below a third of 50 MHz
  task automatic put(input logic b);
    hd = b;
    hoe = 1'b1;
    #80 hclk = 1'b1;
    #80 hclk = 1'b0;
  endtask
  // Release data, sample just before the rise
  task automatic get(output logic b);
    hoe = 1'b0;
    #80 b = pin.dat;
    hclk = 1'b1;
    #80 hclk = 1'b0;
  endtask
  // Acquire pattern, first bit is bit 0
  task automatic acquire();
    logic [15:0] s;
    s = `ACQ_SEQ;
    for (int i = 0; i < 16; i++)
      put(s[i]);
  endtask
  // Packet: header, turn, ack, data with even parity, idle
  task automatic xfer(input logic rnw, input logic [1:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic [2:0] ack);
    logic [7:0] h;
    logic b;
    h = {1'b1, 1'b0, rnw ^ a[1] ^ a[0], a[1], a[0], rnw, 1'b0, 1'b1};
    rd = 32'h0;
    for (int i = 0; i < 8; i++)
      put(h[i]);
    get(b);
    for (int i = 0; i < 3; i++)
      get(ack[i]);
    if (rnw)
    begin
      for (int i = 0; i < 32; i++)
        get(rd[i]);
      get(b);
      get(b);
    end
    else
    begin
      get(b);
      for (int i = 0; i < 32; i++)
        put(wd[i]);
      put(^wd);
    end
    put(1'b0);
    put(1'b0);
  endtask
endmodule

// ===== dv/swd_access_lock_bench.sv
// Self-checking testbench of the debug access block
`timescale 1ns/1ps
`include "swd_lock_regs.svh"
module swd_access_lock_bench;
  localparam logic [31:0] KEY = `LOCK_KEY ^ 32'h0000_000f; // Four bits off, still a match
  logic clk_sys = 1'b0; // System clock
  logic sys_rst = 1'b1; // Synchronous reset
  logic por = 1'b1; // Cell clear
  logic swo_data = 1'b0; // Trace stream
  logic jtag_swd_en = 1'b0; // JTAG enable pulse
  logic blk_req = 1'b0; // Block request
  logic [2:0] blk_idx = 3'h0; // Block number
  logic [3:0] addr = 4'h0; // Bus address
  logic [31:0] wdata = 32'h0; // Bus write data
  logic we = 1'b0; // Write strobe
  logic re = 1'b0; // Read strobe
  logic saw_erase = 1'b0; // Erase pulse seen
  logic [31:0] rd; // Serial read data
  logic [2:0] ack; // Serial acknowledge
  swd_lock_pkg::pair_in_type jtag_in; // Mode pair
  swd_lock_pkg::pair_in_type usb_in; // USB pair
  logic tms_out, tms_oe, dm_out, dm_oe, tdo_out, tdo_oe, ptrace_en, jtag_en; // Pin and port outputs
  logic swd_on, swd_usb, locked, cpu_halt, cpu_step, erase_all, blk_grant; // Status outputs
  logic [31:0] rdata; // Bus read data
  int num_errors = 0; // Mismatches
  int checked = 0; // Comparisons
  ////////////////////////////////
  // Clock, trace and erase monitor
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) swo_data <= ~swo_data;
  always @(posedge clk_sys) if (erase_all === 1'b1) saw_erase <= 1'b1;
  swd_host_model host_jtag (.dev_out(tms_out), .dev_oe(tms_oe), .pin(jtag_in));
  swd_host_model host_usb (.dev_out(dm_out), .dev_oe(dm_oe), .pin(usb_in));
  swd_access_lock swd_access_lock_i (.clk_sys, .sys_rst, .por, .jtag_in, .usb_in, .tms_out, .tms_oe, .dm_out,
    .dm_oe, .gpio_tms_out(swo_data), .gpio_tms_oe(swo_data), .gpio_dm_out(~swo_data), .gpio_dm_oe(1'b0),
    .jtag_tdo(~swo_data), .jtag_tdo_oe(1'b1), .swo_data, .tdo_out, .tdo_oe, .ptrace_en, .jtag_swd_en, .jtag_en,
    .swd_on, .swd_usb, .locked, .cpu_halt, .cpu_step, .erase_all, .blk_req, .blk_idx, .blk_grant, .addr, .wdata,
    .we, .re, .rdata);
  ////////////////////////////////
  // Shared tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic fw_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys) {addr, wdata, we} <= {a, d, 1'b1};
    @(posedge clk_sys) we <= 1'b0;
  endtask
  task automatic fw_rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    @(posedge clk_sys) {addr, re} <= {a, 1'b1};
    @(posedge clk_sys) re <= 1'b0;
    #1 check(nm, rdata, e);
  endtask
  task automatic swd(input logic rnw, input logic [1:0] a, input logic [31:0] d);
    host_usb.xfer(rnw, a, d, rd, ack);
    check("ack", {29'h0, ack}, 32'h1);
  endtask
  task automatic reset_dut(input logic p);
    @(posedge clk_sys) {por, sys_rst} <= {p, 1'b1};
    repeat (20) @(posedge clk_sys);
    {por, sys_rst} <= 2'b00;
  endtask
  task automatic settle();
    repeat (6) @(posedge clk_sys);
    #1;
  endtask
  task automatic stop_test();
    $display("CHECKED %0d ERRORS %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    #1000000;
    num_errors++;
    stop_test();
  end
  // Main sequence
  initial
  begin
    reset_dut(1'b1);
    #1 check("reset", {28'h0, swd_on, jtag_en, ptrace_en, cpu_halt}, 32'h4);
    fw_rd(`FW_STAT_OFS, 32'h6, "stat");
    fw_rd(4'h2, 32'h0, "unmapped");
    repeat (420) @(posedge clk_sys);
    host_jtag.acquire();
    settle();
    check("late acquire", 32'(swd_on), 32'h0);
    @(posedge clk_sys) jtag_swd_en <= 1'b1;
    @(posedge clk_sys) jtag_swd_en <= 1'b0;
    settle();
    check("jtag enable", {30'h0, swd_on, swd_usb}, 32'h2);
    reset_dut(1'b0);
    host_usb.acquire();
    host_jtag.acquire();
    settle();
    check("usb acquire", {30'h0, swd_on, swd_usb}, 32'h3);
    fw_rd(`FW_STAT_OFS, 32'h1e, "stat usb");
    swd(1'b1, `DP_ID_IDX, 32'h0);
    check("id", rd, {`DEV_ID, 8'h00, `NUM_ADDR_BP, `NUM_LIT_BP});
    fw_wr(`FW_CTRL_OFS, 32'h3);
    swd(1'b0, `DP_CTRL_IDX, 32'h4);
    settle();
    check("jtag off halt", {30'h0, jtag_en, cpu_halt}, 32'h1);
    check("wire trace", {30'h0, tdo_out, tdo_oe}, {30'h0, swo_data, 1'b1});
    fw_wr(`FW_CTRL_OFS, 32'h5);
    settle();
    check("parallel trace", 32'(ptrace_en), 32'h1);
    swd(1'b0, `DP_CTRL_IDX, 32'h9);
    settle();
    check("jtag back", {30'h0, jtag_en, cpu_halt}, 32'h2);
    fw_wr(`FW_PERM_OFS, 32'h5);
    blk_req <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_sys) blk_idx <= 3'(i);
      #1 check("grant", 32'(blk_grant), 32'(i != 1));
    end
    fw_wr(`FW_PROT_OFS, 32'h2);
    fw_wr(`FW_PROT_OFS, 32'h1);
    fw_rd(`FW_PROT_OFS, 32'h2, "prot kept");
    swd(1'b0, `DP_KEY_IDX, KEY);
    fw_rd(`FW_STAT_OFS, 32'h1c, "key refused");
    swd(1'b0, `DP_CTRL_IDX, 32'h11);
    fw_rd(`FW_PROT_OFS, 32'h0, "prot erased");
    check("erase", 32'(saw_erase), 32'h1);
    swd(1'b0, `DP_KEY_IDX, KEY);
    fw_rd(`FW_STAT_OFS, 32'h1e, "key taken");
    swd(1'b0, `DP_CTRL_IDX, 32'h21);
    swd(1'b1, `DP_LATCH_IDX, 32'h0);
    check("latch", rd, KEY);
    check("still open", {30'h0, locked, swd_on}, 32'h1);
    reset_dut(1'b0);
    #1 check("locked", {30'h0, locked, jtag_en}, 32'h2);
    fw_wr(`FW_PERM_OFS, 32'h5);
    host_usb.acquire();
    settle();
    check("locked out", {30'h0, swd_on, blk_grant}, 32'h0);
    stop_test();
  end
endmodule
